// ---- hw/dscp_prio_pkg.sv ----
package dscp_prio_pkg;

   // ----------------------------------------------------------------
   // Register map, byte offsets on the management port
   // ----------------------------------------------------------------
   localparam logic [15:0] OFF_MAP_1A_1B = 16'h034d;
   localparam logic [15:0] OFF_MAP_1C_1D = 16'h034e;
   localparam logic [15:0] OFF_MAP_1E_1F = 16'h034f;
   localparam logic [15:0] OFF_MAP_20_21 = 16'h0350;
   localparam logic [15:0] OFF_MAP_22_23 = 16'h0351;
   localparam logic [15:0] OFF_MAP_24_25 = 16'h0352;
   localparam logic [15:0] OFF_MAP_26_27 = 16'h0353;
   localparam logic [15:0] OFF_MAP_28_29 = 16'h0354;
   localparam logic [15:0] OFF_MAP_2A_2B = 16'h0355;
   // Printed offset of the 2C/2D entry collides with the 20/21 entry
   localparam logic [15:0] OFF_MAP_2C_2D_PRINTED = 16'h0350;
   // Decoded offset of the 2C/2D entry: the free slot in the sequence
   localparam logic [15:0] OFF_MAP_2C_2D = 16'h0356;
   localparam logic [15:0] OFF_MAP_2E_2F = 16'h0357;
   localparam logic [15:0] OFF_MAP_30_31 = 16'h0358;
   localparam logic [15:0] OFF_MAP_32_33 = 16'h0359;
   localparam logic [15:0] OFF_MAP_34_35 = 16'h035a;

   // ----------------------------------------------------------------
   // Field layout and reset values
   // ----------------------------------------------------------------
   localparam int PRIO_W = 3;          // Width of one priority field
   localparam int PRIO_LO_LSB = 0;     // Even code point field, bits 2:0
   localparam int PRIO_HI_LSB = 4;     // Odd code point field, bits 6:4
   localparam logic [PRIO_W-1:0] PRIO_RST = 3'h0;
   localparam logic [7:0] RDATA_IDLE = 8'h00;

   // ----------------------------------------------------------------
   // Table geometry
   // ----------------------------------------------------------------
   localparam int NUM_REGS = 14;
   localparam int IDX_W = 4;
   localparam logic [5:0] DSCP_FIRST = 6'h1a;
   localparam logic [5:0] DSCP_LAST = 6'h35;

   // One mapping register: two priority fields
   typedef struct packed {
      logic [PRIO_W-1:0] hi;           // Odd code point
      logic [PRIO_W-1:0] lo;           // Even code point
   } prio_pair_s;

   // Result of an address decode
   typedef struct packed {
      logic hit;
      logic [IDX_W-1:0] idx;
   } reg_sel_s;

   // Lookup answer towards the classifier
   typedef struct packed {
      logic valid;
      logic hit;
      logic [PRIO_W-1:0] prio;
   } prio_result_s;

endpackage

// ---- hw/prio_pair_reg.sv ----
`timescale 1ns/10ps

// --------------------------------------------------------------------
// One mapping register holding two 3-bit priorities
// --------------------------------------------------------------------
module prio_pair_reg
   import dscp_prio_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [7:0] wdata,
   output prio_pair_s pair
);

   prio_pair_s pair_d;                 // Next value
   prio_pair_s pair_q;                 // Stored fields

   // Next value: only the two priority fields are captured, so bits 7
   // and 3 of a write fall away here and never reach storage
   always_comb begin
      pair_d = pair_q;
      if (wr_en) begin
         pair_d.lo = wdata[PRIO_LO_LSB +: PRIO_W];
         pair_d.hi = wdata[PRIO_HI_LSB +: PRIO_W];
      end
   end

   // Storage, cleared to zero priority by reset
   always_ff @(posedge mclk) begin
      if (rst) begin
         pair_q <= '{hi: PRIO_RST, lo: PRIO_RST};
      end else begin
         pair_q <= pair_d;
      end
   end

   assign pair = pair_q;

endmodule

// ---- hw/dscp_priority_map_1a_35.sv ----
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps

// Functional notes
// R01 - DSCP 1A/1B from register 034D, reset zero
// R02 - DSCP 1C/1D from register 034E
// R03 - DSCP 1E/1F from register 034F
// R04 - DSCP 20/21 from register 0350
// R05 - DSCP 22/23 from register 0351
// R06 - DSCP 24/25 from register 0352
// R07 - DSCP 26/27 from register 0353
// R08 - DSCP 28/29 from register 0354
// R09 - DSCP 2A/2B from register 0355
// R10 - DSCP 2C/2D from register 0356; the printed 0350 entry is a duplicate
// R11 - DSCP 2E/2F from register 0357
// R12 - DSCP 30/31 from register 0358
// R13 - DSCP 32/33 from register 0359
// R14 - DSCP 34/35 from 035A; all fields reset zero
// R15 - Bits 7 and 3 read zero, ignore writes
module dscp_priority_map_1a_35
   import dscp_prio_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic lookup_valid,
   input wire logic [5:0] lookup_dscp,
   output logic prio_valid,
   output logic prio_hit,
   output logic [2:0] prio_out
);

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------

   // Maps a byte offset onto a table slot; the 2C/2D entry answers at
   // the free slot so that it never shadows the 20/21 entry
   function automatic reg_sel_s decode(input logic [15:0] addr);
      reg_sel_s sel;
      sel = '{hit: 1'b1, idx: 4'h0};
      // R01 1A/1B entry
      if (addr == OFF_MAP_1A_1B) begin
         sel.idx = 4'h0;
      // R02 1C/1D entry
      end else if (addr == OFF_MAP_1C_1D) begin
         sel.idx = 4'h1;
      // R03 1E/1F entry
      end else if (addr == OFF_MAP_1E_1F) begin
         sel.idx = 4'h2;
      // R04 20/21 entry
      end else if (addr == OFF_MAP_20_21) begin
         sel.idx = 4'h3;
      // R05 22/23 entry
      end else if (addr == OFF_MAP_22_23) begin
         sel.idx = 4'h4;
      // R06 24/25 entry
      end else if (addr == OFF_MAP_24_25) begin
         sel.idx = 4'h5;
      // R07 26/27 entry
      end else if (addr == OFF_MAP_26_27) begin
         sel.idx = 4'h6;
      // R08 28/29 entry
      end else if (addr == OFF_MAP_28_29) begin
         sel.idx = 4'h7;
      // R09 2A/2B entry
      end else if (addr == OFF_MAP_2A_2B) begin
         sel.idx = 4'h8;
      // R10 2C/2D entry
      end else if (addr == OFF_MAP_2C_2D) begin
         sel.idx = 4'h9;
      // R11 2E/2F entry
      end else if (addr == OFF_MAP_2E_2F) begin
         sel.idx = 4'ha;
      // R12 30/31 entry
      end else if (addr == OFF_MAP_30_31) begin
         sel.idx = 4'hb;
      // R13 32/33 entry
      end else if (addr == OFF_MAP_32_33) begin
         sel.idx = 4'hc;
      // R14 34/35 entry
      end else if (addr == OFF_MAP_34_35) begin
         sel.idx = 4'hd;
      end else begin
         // Unmapped: writes dropped, reads answer zero
         sel.hit = 1'b0;
      end
      return sel;
   endfunction

   reg_sel_s sel;                      // Decode of the current address

   always_comb begin
      sel = decode(reg_addr);
   end

   // ----------------------------------------------------------------
   // Mapping registers
   // ----------------------------------------------------------------
   prio_pair_s [NUM_REGS-1:0] map_q;   // All fourteen entries

   // R14 zero on reset
   // R01 one slot each
   // Every slot is the same register; the decode picks the slot
   for (genvar gi = 0; gi < NUM_REGS; gi++) begin : g_map
      localparam logic [IDX_W-1:0] SLOT = IDX_W'(gi);
      prio_pair_reg u_reg (
         .mclk(mclk),
         .rst(rst),
         .wr_en(reg_wr && sel.hit && (sel.idx == SLOT)),
         .wdata(reg_wdata),
         .pair(map_q[gi])
      );
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   logic [7:0] rdata_d;                // Next read data
   logic [7:0] rdata_q;                // Read data, one cycle after strobe

   // R15 reserved bits zero
   // Read data stand only in the cycle after the strobe, else zero
   always_comb begin
      rdata_d = RDATA_IDLE;
      if (reg_rd && sel.hit) begin
         rdata_d = {1'b0, map_q[sel.idx].hi, 1'b0, map_q[sel.idx].lo};
      end
   end

   // Read data register
   always_ff @(posedge mclk) begin
      if (rst) begin
         rdata_q <= RDATA_IDLE;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

   // ----------------------------------------------------------------
   // Priority lookup
   // ----------------------------------------------------------------
   logic [5:0] code_off;               // Code point relative to first entry
   logic in_range;                     // Code point handled by this slice
   prio_result_s res_d;                // Next lookup answer
   prio_result_s res_q;                // Registered lookup answer

   assign code_off = lookup_dscp - DSCP_FIRST;
   assign in_range = (lookup_dscp >= DSCP_FIRST) && (lookup_dscp <= DSCP_LAST);

   // R02 select by code
   // Pair index is the offset halved, the low bit picks odd or even.
   // A write in the same cycle as a lookup is seen one lookup later,
   // which keeps the lookup path free of the write decode.
   always_comb begin
      res_d = '{valid: 1'b0, hit: 1'b0, prio: PRIO_RST};
      if (lookup_valid) begin
         res_d.valid = 1'b1;
         res_d.hit = in_range;
         if (in_range) begin
            if (code_off[0]) begin
               res_d.prio = map_q[code_off[4:1]].hi;
            end else begin
               res_d.prio = map_q[code_off[4:1]].lo;
            end
         end
      end
   end

   // Lookup answer register
   always_ff @(posedge mclk) begin
      if (rst) begin
         res_q <= '{valid: 1'b0, hit: 1'b0, prio: PRIO_RST};
      end else begin
         res_q <= res_d;
      end
   end

   assign prio_valid = res_q.valid;
   assign prio_hit = res_q.hit;
   assign prio_out = res_q.prio;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------

   // Lookup of a code one cycle, answer the next
   sequence look_at(logic [5:0] code);
      lookup_valid && (lookup_dscp == code);
   endsequence

   // Write of a register offset
   sequence write_at(logic [15:0] off);
      reg_wr && (reg_addr == off);
   endsequence

   map_1a_1b_a: assert property (@(posedge mclk) disable iff (rst) // R01
      look_at(6'h1b) |=> prio_hit && (prio_out == $past(map_q[0].hi)))
      else $error("1B lookup does not return register 034D high field");

   map_1c_1d_a: assert property (@(posedge mclk) disable iff (rst) // R02
      write_at(OFF_MAP_1C_1D) |=> (map_q[1] == {$past(reg_wdata[6:4]), $past(reg_wdata[2:0])}))
      else $error("Write to 034E not stored in 1C/1D entry");

   map_1e_1f_a: assert property (@(posedge mclk) disable iff (rst) // R03
      write_at(OFF_MAP_1E_1F) ##1 look_at(6'h1e) |=> (prio_out == $past(reg_wdata[2:0], 2)))
      else $error("1E lookup after write to 034F is wrong");

   map_20_21_a: assert property (@(posedge mclk) disable iff (rst) // R04
      write_at(OFF_MAP_20_21) |=> (map_q[3] == {$past(reg_wdata[6:4]), $past(reg_wdata[2:0])})
      and $stable(map_q[9]))
      else $error("Write to 0350 wrong or disturbs 2C/2D entry");

   map_22_23_a: assert property (@(posedge mclk) disable iff (rst) // R05
      write_at(OFF_MAP_22_23) ##1 look_at(6'h23) |=> (prio_out == $past(reg_wdata[6:4], 2)))
      else $error("23 lookup after write to 0351 is wrong");

   map_24_25_a: assert property (@(posedge mclk) disable iff (rst) // R06
      write_at(OFF_MAP_24_25) |=> (map_q[5] == {$past(reg_wdata[6:4]), $past(reg_wdata[2:0])}))
      else $error("Write to 0352 not stored in 24/25 entry");

   map_26_27_a: assert property (@(posedge mclk) disable iff (rst) // R07
      look_at(6'h26) |=> prio_valid && (prio_out == $past(map_q[6].lo)))
      else $error("26 lookup does not return register 0353 low field");

   map_28_29_a: assert property (@(posedge mclk) disable iff (rst) // R08
      write_at(OFF_MAP_28_29) ##1 (reg_rd && reg_addr == OFF_MAP_28_29 && !reg_wr)
      |=> (reg_rdata == ($past(reg_wdata, 2) & 8'h77)))
      else $error("Readback of 0354 differs from written value");

   map_2a_2b_a: assert property (@(posedge mclk) disable iff (rst) // R09
      write_at(OFF_MAP_2A_2B) |=> (map_q[8] == {$past(reg_wdata[6:4]), $past(reg_wdata[2:0])}))
      else $error("Write to 0355 not stored in 2A/2B entry");

   map_2c_2d_a: assert property (@(posedge mclk) disable iff (rst) // R10
      write_at(OFF_MAP_2C_2D) ##1 look_at(6'h2d) |=> (prio_out == $past(reg_wdata[6:4], 2)))
      else $error("2D lookup after write to 2C/2D entry is wrong");

   map_2e_2f_a: assert property (@(posedge mclk) disable iff (rst) // R11
      write_at(OFF_MAP_2E_2F) |=> (map_q[10] == {$past(reg_wdata[6:4]), $past(reg_wdata[2:0])}))
      else $error("Write to 0357 not stored in 2E/2F entry");

   map_30_31_a: assert property (@(posedge mclk) disable iff (rst) // R12
      look_at(6'h31) |=> prio_hit && (prio_out == $past(map_q[11].hi)))
      else $error("31 lookup does not return register 0358 high field");

   map_32_33_a: assert property (@(posedge mclk) disable iff (rst) // R13
      write_at(OFF_MAP_32_33) ##1 look_at(6'h32) |=> (prio_out == $past(reg_wdata[2:0], 2)))
      else $error("32 lookup after write to 0359 is wrong");

   reset_zero_a: assert property (@(posedge mclk) // R14
      $fell(rst) |-> (map_q == '0) && !prio_valid && (reg_rdata == RDATA_IDLE))
      else $error("Table or outputs not cleared after reset");

   map_34_35_a: assert property (@(posedge mclk) disable iff (rst) // R14
      write_at(OFF_MAP_34_35) ##1 look_at(6'h35) |=> (prio_out == $past(reg_wdata[6:4], 2)))
      else $error("35 lookup after write to 035A is wrong");

   reserved_bits_a: assert property (@(posedge mclk) disable iff (rst) // R15
      (reg_rdata[7] == 1'b0) && (reg_rdata[3] == 1'b0))
      else $error("Reserved read bit seen high");

   range_miss_a: assert property (@(posedge mclk) disable iff (rst) // R02
      (lookup_valid && (lookup_dscp < DSCP_FIRST || lookup_dscp > DSCP_LAST))
      |=> prio_valid && !prio_hit && (prio_out == PRIO_RST))
      else $error("Out of range code point reported as a hit");

   read_once_a: assert property (@(posedge mclk) disable iff (rst) // R15
      !reg_rd |=> (reg_rdata == RDATA_IDLE))
      else $error("Read data present without a read strobe");

   // Every entry is reached by at least one of its codes; the slot
   // numbers follow the table order, so a wrong pair index shows here
   // even when no write comes just before the lookup.

   look_1a_a: assert property (@(posedge mclk) disable iff (rst) // R01
      look_at(6'h1a) |=> prio_hit && (prio_out == $past(map_q[0].lo)))
      else $error("1A lookup does not return register 034D low field");

   look_1d_a: assert property (@(posedge mclk) disable iff (rst) // R02
      look_at(6'h1d) |=> prio_hit && (prio_out == $past(map_q[1].hi)))
      else $error("1D lookup does not return register 034E high field");

   look_1f_a: assert property (@(posedge mclk) disable iff (rst) // R03
      look_at(6'h1f) |=> prio_hit && (prio_out == $past(map_q[2].hi)))
      else $error("1F lookup does not return register 034F high field");

   look_20_a: assert property (@(posedge mclk) disable iff (rst) // R04
      look_at(6'h20) |=> prio_hit && (prio_out == $past(map_q[3].lo)))
      else $error("20 lookup does not return register 0350 low field");

   look_22_a: assert property (@(posedge mclk) disable iff (rst) // R05
      look_at(6'h22) |=> prio_hit && (prio_out == $past(map_q[4].lo)))
      else $error("22 lookup does not return register 0351 low field");

   look_25_a: assert property (@(posedge mclk) disable iff (rst) // R06
      look_at(6'h25) |=> prio_hit && (prio_out == $past(map_q[5].hi)))
      else $error("25 lookup does not return register 0352 high field");

   look_27_a: assert property (@(posedge mclk) disable iff (rst) // R07
      look_at(6'h27) |=> prio_hit && (prio_out == $past(map_q[6].hi)))
      else $error("27 lookup does not return register 0353 high field");

   look_28_a: assert property (@(posedge mclk) disable iff (rst) // R08
      look_at(6'h28) |=> prio_hit && (prio_out == $past(map_q[7].lo)))
      else $error("28 lookup does not return register 0354 low field");

   look_2b_a: assert property (@(posedge mclk) disable iff (rst) // R09
      look_at(6'h2b) |=> prio_hit && (prio_out == $past(map_q[8].hi)))
      else $error("2B lookup does not return register 0355 high field");

   look_2c_a: assert property (@(posedge mclk) disable iff (rst) // R10
      look_at(6'h2c) |=> prio_hit && (prio_out == $past(map_q[9].lo)))
      else $error("2C lookup does not return the 2C/2D entry low field");

   look_2e_a: assert property (@(posedge mclk) disable iff (rst) // R11
      look_at(6'h2e) |=> prio_hit && (prio_out == $past(map_q[10].lo)))
      else $error("2E lookup does not return register 0357 low field");

   look_30_a: assert property (@(posedge mclk) disable iff (rst) // R12
      look_at(6'h30) |=> prio_hit && (prio_out == $past(map_q[11].lo)))
      else $error("30 lookup does not return register 0358 low field");

   look_33_a: assert property (@(posedge mclk) disable iff (rst) // R13
      look_at(6'h33) |=> prio_hit && (prio_out == $past(map_q[12].hi)))
      else $error("33 lookup does not return register 0359 high field");

   look_34_a: assert property (@(posedge mclk) disable iff (rst) // R14
      look_at(6'h34) |=> prio_hit && (prio_out == $past(map_q[13].lo)))
      else $error("34 lookup does not return register 035A low field");

   // One answer for every request, none without one
   answer_next_a: assert property (@(posedge mclk) disable iff (rst) // R02
      lookup_valid |=> prio_valid)
      else $error("Lookup request not answered on the next cycle");

   answer_once_a: assert property (@(posedge mclk) disable iff (rst) // R02
      !lookup_valid |=> !prio_valid)
      else $error("Lookup answer present without a request");

endmodule

// ---- verification/dscp_priority_map_1a_35_tb.sv ----
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Self-checking bench for the 0x1A..0x35 priority map
// ----------------------------------------------------------------
module dscp_priority_map_1a_35_tb;
   import dscp_prio_pkg::*;

   logic mclk;                    // Core clock, 50 ns period
   logic rst;                     // Synchronous reset, active high
   logic [15:0] reg_addr;         // Register offset
   logic [7:0] reg_wdata;         // Write data
   logic reg_wr;                  // Write strobe
   logic reg_rd;                  // Read strobe
   logic [7:0] reg_rdata;         // Read data, cycle after the strobe
   logic lookup_valid;            // Lookup request
   logic [5:0] lookup_dscp;       // Code point to look up
   logic prio_valid;              // Lookup answer strobe
   logic prio_hit;                // Code lies in this slice
   logic [2:0] prio_out;          // Priority found
   int miscompares;               // Mismatches seen
   int total_checks;              // Comparisons made
   int cycles;                    // Clock count for the hang guard
   logic [15:0] offs [NUM_REGS];  // Offsets in table order
   logic [7:0] shadow [NUM_REGS]; // Expected register contents

   dscp_priority_map_1a_35 DUT (
      .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .lookup_valid(lookup_valid), .lookup_dscp(lookup_dscp),
      .prio_valid(prio_valid), .prio_hit(prio_hit), .prio_out(prio_out)
   );

   // ----------------------------------------------------------------
   // Clock and hang guard
   // ----------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // Whole run needs about 1000 cycles; the ceiling leaves wide margin
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 8000) begin
         miscompares++;
         $display("[ERR] %0t run did not finish in time", $time);
         conclude();
      end
   end

   // ----------------------------------------------------------------
   // Compare and report tasks
   // ----------------------------------------------------------------
   task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t read data %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_prio(input prio_result_s got, input prio_result_s exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t lookup %h answered %b, expected %b", $time,
                  lookup_dscp, got, exp);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Expected answer worked out from the shadow copy, never from the design
   function automatic prio_result_s expect_for(input logic [5:0] c);
      int i;
      prio_result_s r;
      r = '0;
      r.valid = 1'b1;
      if (c >= DSCP_FIRST && c <= DSCP_LAST) begin
         i = int'(c - DSCP_FIRST) >> 1;
         r.hit = 1'b1;
         // Even code uses bits 2:0, odd code bits 6:4
         r.prio = c[0] ? shadow[i][6:4] : shadow[i][2:0];
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Access tasks: strobes driven just after a rising edge
   // ----------------------------------------------------------------
   task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic reg_read(input logic [15:0] a, input logic [7:0] exp);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 chk_data(reg_rdata, exp);
   endtask

   task automatic look(input logic [5:0] c);
      @(posedge mclk);
      lookup_valid <= 1'b1;
      lookup_dscp <= c;
      @(posedge mclk);
      lookup_valid <= 1'b0;
      #1 chk_prio({prio_valid, prio_hit, prio_out}, expect_for(c));
   endtask

   // Write, then a read or a lookup on the very next edge, with no gap
   task automatic write_then(input logic [15:0] a, input logic [7:0] d,
                             input bit rd, input logic [5:0] c, input int i);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_rd <= rd;
      lookup_valid <= !rd;
      lookup_dscp <= c;
      shadow[i] = {1'b0, d[6:4], 1'b0, d[2:0]};
      @(posedge mclk);
      reg_rd <= 1'b0;
      lookup_valid <= 1'b0;
      #1;
      if (rd) begin
         chk_data(reg_rdata, shadow[i]);
         // Read data must be gone one cycle later
         @(posedge mclk);
         #1 chk_data(reg_rdata, 8'h00);
      end else begin
         chk_prio({prio_valid, prio_hit, prio_out}, expect_for(c));
      end
   endtask

   // Reads every register and looks up all 64 code points
   task automatic sweep();
      for (int i = 0; i < NUM_REGS; i++) begin
         reg_read(offs[i], shadow[i]);
      end
      for (int c = 0; c < 64; c++) begin
         look(6'(c));
      end
   endtask

   task automatic apply_reset();
      @(posedge mclk);
      rst <= 1'b1;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      for (int i = 0; i < NUM_REGS; i++) begin
         shadow[i] = 8'h00;
      end
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      offs = '{OFF_MAP_1A_1B, OFF_MAP_1C_1D, OFF_MAP_1E_1F, OFF_MAP_20_21,
               OFF_MAP_22_23, OFF_MAP_24_25, OFF_MAP_26_27, OFF_MAP_28_29,
               OFF_MAP_2A_2B, OFF_MAP_2C_2D, OFF_MAP_2E_2F, OFF_MAP_30_31,
               OFF_MAP_32_33, OFF_MAP_34_35};
      rst = 1'b1;
      reg_addr = 16'h0000;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      lookup_valid = 1'b0;
      lookup_dscp = 6'h00;
      miscompares = 0;
      total_checks = 0;
      cycles = 0;
      apply_reset();
      // Every field starts at zero
      sweep();
      // Idle cycles show zero read data and no answer
      @(posedge mclk);
      #1 chk_data(reg_rdata, 8'h00);
      chk_prio({prio_valid, prio_hit, prio_out}, 5'h00);
      $display("test reset values done");

      // Bits 7 and 3 are set on purpose; they must be dropped
      for (int i = 0; i < NUM_REGS; i++) begin
         reg_write(offs[i], {1'b1, 3'(i + 1), 1'b1, 3'(6 - i)});
         shadow[i] = {1'b0, 3'(i + 1), 1'b0, 3'(6 - i)};
      end
      sweep();
      $display("test programmed table done");

      // Unmapped neighbours: writes ignored, reads give zero
      reg_write(16'h034c, 8'hff);
      reg_write(16'h035b, 8'hff);
      reg_read(16'h034c, 8'h00);
      reg_read(16'h035b, 8'h00);
      reg_read(16'h0000, 8'h00);
      sweep();
      $display("test unmapped offsets done");

      // The repeated printed offset reaches the 20/21 entry only
      reg_write(OFF_MAP_2C_2D_PRINTED, 8'h25);
      shadow[3] = 8'h25;
      sweep();
      $display("test repeated offset done");

      // A lookup beside a write still sees the old value
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= OFF_MAP_1A_1B;
      reg_wdata <= 8'h73;
      lookup_valid <= 1'b1;
      lookup_dscp <= 6'h1a;
      @(posedge mclk);
      reg_wr <= 1'b0;
      lookup_valid <= 1'b0;
      #1 chk_prio({prio_valid, prio_hit, prio_out}, expect_for(6'h1a));
      shadow[0] = 8'h73;
      look(6'h1a);
      look(6'h1b);
      $display("test write beside lookup done");

      // Back-to-back: a write, then a lookup or read on the next edge
      write_then(OFF_MAP_1E_1F, 8'h45, 1'b0, 6'h1e, 2);
      write_then(OFF_MAP_22_23, 8'h36, 1'b0, 6'h23, 4);
      write_then(OFF_MAP_28_29, 8'hda, 1'b1, 6'h00, 7);
      write_then(OFF_MAP_2C_2D, 8'h71, 1'b0, 6'h2d, 9);
      write_then(OFF_MAP_32_33, 8'h27, 1'b0, 6'h32, 12);
      write_then(OFF_MAP_34_35, 8'h5c, 1'b0, 6'h35, 13);
      // Lookups held on consecutive edges answer one per cycle
      @(posedge mclk);
      lookup_valid <= 1'b1;
      lookup_dscp <= 6'h2c;
      @(posedge mclk);
      lookup_dscp <= 6'h2d;
      #1 chk_prio({prio_valid, prio_hit, prio_out}, expect_for(6'h2c));
      @(posedge mclk);
      lookup_valid <= 1'b0;
      #1 chk_prio({prio_valid, prio_hit, prio_out}, expect_for(6'h2d));
      sweep();
      $display("test back-to-back access done");

      // A second reset clears the whole table again
      apply_reset();
      sweep();
      $display("test second reset done");
      conclude();
   end

endmodule
